// file: verilog/csc_regbank.sv
`timescale 1ns/1ns
module csc_regbank #(
  parameter int RAMP_CYC = csc_pkg::RAMP_CYCLES,
  parameter int SIL_LEN  = csc_pkg::SILENCE_SAMPLES
) (
  input  wire logic             ref_clk,
  input  wire logic             rst_n,
  input  wire logic             i2c_mode,
  input  wire logic             addr_load,
  input  wire csc_pkg::csc_addr_t addr_in,
  input  wire logic             word_wr,
  input  wire csc_pkg::csc_data_t wr_data,
  input  wire logic             word_rd,
  output csc_pkg::csc_data_t    rd_data,
  output logic                  rd_valid,
  output csc_pkg::csc_addr_t    addr_ptr,
  input  wire logic             sdo_bit,
  input  wire logic             sdo_active,
  output logic                  sdo_o,
  output logic                  sdo_oe,
  input  wire logic             overtemp_pin,
  input  wire logic             regulator_low_pin,
  input  wire logic             pin1_event,
  input  wire logic             pin2_event,
  input  wire logic [3:0]       pin1_function_select,
  input  wire logic [3:0]       pin2_function_select,
  output logic                  pin1_irq_drive,
  output logic                  pin2_irq_drive,
  output logic                  irq_req,
  input  wire logic             pb_stb,
  input  wire logic signed [15:0] pb_in,
  output logic signed [15:0]    pb_out,
  output logic signed [10:0]    pb_gain_eighth_db,
  output logic                  pb_gain_mute,
  output logic                  playback_filter_select,
  input  wire logic             rec_stb,
  input  wire logic signed [15:0] rec_l_in,
  input  wire logic signed [15:0] rec_r_in,
  output logic signed [15:0]    rec_l_out,
  output logic signed [15:0]    rec_r_out
);
  import csc_pkg::*;

  // ==========================================================
  // gain code to 0.125 dB units, code 0 handled as mute
  function automatic logic signed [10:0] gain_db8(input logic [7:0] c);
    logic signed [10:0] d;
    d = $signed({3'h0, c}) - $signed({3'h0, GAIN_UNITY});
    gain_db8 = 11'(d * $signed(GAIN_STEP8));
  endfunction
  // negation saturates so the most negative code cannot wrap
  function automatic logic signed [15:0] flip(input logic signed [15:0] x);
    flip = (x == 16'sh8000) ? 16'sh7FFF : 16'(-x);
  endfunction

  // ==========================================================
  // live inputs
  logic [1:0] live_q;
  logic       overtemp_state;
  logic       regulator_low_state;
  logic       overtemp_d_r;
  logic       reglow_d_r;
  csc_sync #(.W(2)) u_sync (
    .ref_clk  (ref_clk),
    .rst_n    (rst_n),
    .async_in ({overtemp_pin, regulator_low_pin}),
    .sync_out (live_q)
  );
  assign overtemp_state      = live_q[1];
  assign regulator_low_state = live_q[0];

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      overtemp_d_r <= 1'b0;
      reglow_d_r   <= 1'b0;
    end else begin
      overtemp_d_r <= overtemp_state;
      reglow_d_r   <= regulator_low_state;
    end
  end

  // ==========================================================
  // registers
  csc_data_t pin_gating_r;
  csc_data_t src_masks_r;
  csc_data_t host_opts_r;
  csc_data_t pb_ctrl_a_r;
  csc_data_t pb_ctrl_b_r;
  csc_data_t pb_gain_r;
  csc_data_t rec_ctrl_r;
  csc_data_t event_latch_r;
  csc_data_t event_set;
  csc_data_t live_flags;
  logic      latch_rd;
  logic      request_pin_mask;
  logic      auto_inc;

  assign request_pin_mask = pin_gating_r[BIT_PIN_MASK];
  assign auto_inc         = host_opts_r[BIT_AUTO_INC];
  assign latch_rd         = word_rd && (addr_ptr == ADDR_EVENT_LATCH);

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_gating_r <= RST_PIN_GATING;
      src_masks_r  <= RST_SRC_MASKS;
      host_opts_r  <= RST_HOST_OPTS;
      pb_ctrl_a_r  <= RST_PB_CTRL_A;
      pb_ctrl_b_r  <= RST_PB_CTRL_B;
      pb_gain_r    <= RST_PB_GAIN;
      rec_ctrl_r   <= RST_REC_CTRL;
    end else if (word_wr) begin
      unique case (addr_ptr)
        ADDR_PIN_GATING: pin_gating_r <= wr_data & 16'h0001;
        ADDR_SRC_MASKS:  src_masks_r  <= wr_data & EVENT_BITS;
        ADDR_HOST_OPTS:  host_opts_r  <= wr_data & 16'h0005;
        ADDR_PB_CTRL_A:  pb_ctrl_a_r  <= wr_data & 16'h0011;
        ADDR_PB_CTRL_B:  pb_ctrl_b_r  <= wr_data & 16'h0011;
        ADDR_PB_GAIN:    pb_gain_r    <= wr_data & 16'h01FF;
        ADDR_REC_CTRL:   rec_ctrl_r   <= wr_data & 16'h0103;
        default: ;
      endcase
    end
  end

  // ==========================================================
  // address pointer
  // auto-increment is a 2-wire feature; 3-wire frames carry
  // their own address on every word
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      addr_ptr <= '0;
    end else if (addr_load) begin
      addr_ptr <= addr_in;
    end else if ((word_wr || word_rd) && i2c_mode && auto_inc) begin
      addr_ptr <= addr_ptr + 8'h01;
    end
  end

  // ==========================================================
  // read path
  always_comb begin
    live_flags = '0;
    live_flags[BIT_OVERTEMP] = overtemp_state;
    live_flags[BIT_REGLOW]   = regulator_low_state;
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_data  <= '0;
      rd_valid <= 1'b0;
    end else begin
      rd_valid <= word_rd;
      if (word_rd) begin
        unique case (addr_ptr)
          ADDR_EVENT_LATCH: rd_data <= event_latch_r;
          ADDR_LIVE_FLAGS:  rd_data <= live_flags;
          ADDR_PIN_GATING:  rd_data <= pin_gating_r;
          ADDR_SRC_MASKS:   rd_data <= src_masks_r;
          ADDR_HOST_OPTS:   rd_data <= host_opts_r;
          ADDR_PB_CTRL_A:   rd_data <= pb_ctrl_a_r;
          ADDR_PB_CTRL_B:   rd_data <= pb_ctrl_b_r;
          ADDR_PB_GAIN:     rd_data <= pb_gain_r;
          ADDR_REC_CTRL:    rd_data <= rec_ctrl_r;
          default:          rd_data <= '0;
        endcase
      end
    end
  end

  // ==========================================================
  // event latches and request
  always_comb begin
    event_set = '0;
    event_set[BIT_OVERTEMP] = overtemp_state && !overtemp_d_r;
    event_set[BIT_PIN2]     = pin2_event;
    event_set[BIT_PIN1]     = pin1_event;
    event_set[BIT_REGLOW]   = regulator_low_state && !reglow_d_r;
  end

  // a set in the clearing read's cycle survives the clear
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      event_latch_r <= '0;
    end else if (latch_rd) begin
      event_latch_r <= event_set;
    end else begin
      event_latch_r <= event_latch_r | event_set;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_req        <= 1'b0;
      pin1_irq_drive <= 1'b0;
      pin2_irq_drive <= 1'b0;
    end else begin
      irq_req <= |(event_latch_r & ~src_masks_r) && !request_pin_mask;
      pin1_irq_drive <= (pin1_function_select == FN_IRQ_OUT);
      pin2_irq_drive <= (pin2_function_select == FN_IRQ_OUT);
    end
  end

  // ==========================================================
  // serial data output driver
  // the 2-wire bus is open-drain by nature, so the option only
  // matters in 3-wire mode
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sdo_o  <= 1'b0;
      sdo_oe <= 1'b0;
    end else if (!i2c_mode && !host_opts_r[BIT_OPEN_DRAIN]) begin
      sdo_o  <= sdo_bit;
      sdo_oe <= sdo_active;
    end else begin
      sdo_o  <= 1'b0;
      sdo_oe <= sdo_active && !sdo_bit;
    end
  end

  // ==========================================================
  // volume ramp: one 0.375 dB step per tick
  logic [$clog2(RAMP_CYC+1)-1:0] ramp_cnt_r;
  logic       ramp_tick;
  logic [7:0] gain_now_r;
  logic [7:0] gain_tgt;

  assign gain_tgt  = pb_gain_r[7:0];
  assign ramp_tick = (ramp_cnt_r == '0);

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ramp_cnt_r <= '0;
    end else if (ramp_tick) begin
      ramp_cnt_r <= ($clog2(RAMP_CYC+1))'(RAMP_CYC - 1);
    end else begin
      ramp_cnt_r <= ramp_cnt_r - 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      gain_now_r <= GAIN_UNITY;
    end else if (!pb_ctrl_b_r[BIT_RAMP]) begin
      gain_now_r <= gain_tgt;
    end else if (ramp_tick && gain_now_r < gain_tgt) begin
      gain_now_r <= gain_now_r + 8'h01;
    end else if (ramp_tick && gain_now_r > gain_tgt) begin
      gain_now_r <= gain_now_r - 8'h01;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pb_gain_eighth_db      <= '0;
      pb_gain_mute           <= 1'b1;
      playback_filter_select <= 1'b0;
    end else begin
      pb_gain_eighth_db      <= gain_db8(gain_now_r);
      pb_gain_mute           <= (gain_now_r == 8'h00) ||
                                pb_gain_r[BIT_MUTE];
      playback_filter_select <= pb_ctrl_b_r[BIT_FILTER];
    end
  end

  // ==========================================================
  // playback path: auto-mute after a run of silent samples
  logic [$clog2(SIL_LEN+1)-1:0] sil_cnt_r;
  logic silent;
  assign silent = (sil_cnt_r == ($clog2(SIL_LEN+1))'(SIL_LEN));

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sil_cnt_r <= '0;
    end else if (pb_stb) begin
      if (pb_in != '0) begin
        sil_cnt_r <= '0;
      end else if (!silent) begin
        sil_cnt_r <= sil_cnt_r + 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pb_out <= '0;
    end else if (pb_stb) begin
      if (pb_gain_r[BIT_MUTE]) begin
        pb_out <= '0;
      end else if (pb_ctrl_a_r[BIT_SIL_MUTE] && silent) begin
        pb_out <= '0;
      end else if (pb_ctrl_a_r[BIT_PB_FLIP]) begin
        pb_out <= flip(pb_in);
      end else begin
        pb_out <= pb_in;
      end
    end
  end

  // ==========================================================
  // record path
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rec_l_out <= '0;
      rec_r_out <= '0;
    end else if (rec_stb) begin
      if (rec_ctrl_r[BIT_MUTE]) begin
        rec_l_out <= '0;
        rec_r_out <= '0;
      end else begin
        rec_l_out <= rec_ctrl_r[BIT_REC_LFLIP] ? flip(rec_l_in) : rec_l_in;
        rec_r_out <= rec_ctrl_r[BIT_REC_RFLIP] ? flip(rec_r_in) : rec_r_in;
      end
    end
  end

  // ==========================================================
  // checks
  sequence rd_of(csc_addr_t a);
    word_rd && !addr_load && addr_ptr == a;
  endsequence
  sequence inc_access;
    (word_wr || word_rd) && !addr_load && i2c_mode && auto_inc;
  endsequence

  live_flags_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    rd_of(ADDR_LIVE_FLAGS) |=> rd_valid &&
      rd_data[BIT_OVERTEMP] == $past(overtemp_state))
    else $error("overtemp flag read wrong");
  reglow_flag_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    rd_of(ADDR_LIVE_FLAGS) |=>
      rd_data[BIT_REGLOW] == $past(regulator_low_state))
    else $error("regulator flag read wrong");
  pin_mask_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    request_pin_mask && $past(request_pin_mask) |-> !irq_req)
    else $error("request not gated");
  thermal_mask_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    event_latch_r == 16'h8000 && src_masks_r[BIT_OVERTEMP] |=> !irq_req)
    else $error("thermal mask ignored");
  pin_masks_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (event_latch_r & ~16'h3000) == '0 && src_masks_r[13:12] == 2'h3
      |=> !irq_req)
    else $error("pin masks ignored");
  reglow_mask_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    event_latch_r == 16'h0001 && !src_masks_r[BIT_REGLOW] &&
      !request_pin_mask |=> irq_req)
    else $error("regulator event lost");
  open_drain_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    sdo_oe && (i2c_mode || host_opts_r[BIT_OPEN_DRAIN]) &&
      $past(i2c_mode || host_opts_r[BIT_OPEN_DRAIN]) |-> !sdo_o)
    else $error("open-drain line driven high");
  auto_inc_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    inc_access |=> addr_ptr == $past(addr_ptr) + 8'h01)
    else $error("pointer did not advance");
  mute_out_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    pb_stb && pb_gain_r[BIT_MUTE] |=> pb_out == '0)
    else $error("playback not muted");
  latch_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    event_latch_r[BIT_PIN1] && !latch_rd |=> event_latch_r[BIT_PIN1])
    else $error("latch lost without read");
  rec_mute_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    rec_stb && rec_ctrl_r[BIT_MUTE] |=> rec_l_out == '0 && rec_r_out == '0)
    else $error("record not muted");
endmodule

// file: verilog/csc_pkg.sv
package csc_pkg;
  // ==========================================================
  // bus shape
  localparam int AW = 8;
  localparam int DW = 16;
  typedef logic [AW-1:0] csc_addr_t;
  typedef logic [DW-1:0] csc_data_t;
  // ==========================================================
  // register offsets
  localparam csc_addr_t ADDR_EVENT_LATCH = 8'h10;
  localparam csc_addr_t ADDR_LIVE_FLAGS  = 8'h11;
  localparam csc_addr_t ADDR_PIN_GATING  = 8'h12;
  localparam csc_addr_t ADDR_SRC_MASKS   = 8'h13;
  localparam csc_addr_t ADDR_HOST_OPTS   = 8'h14;
  localparam csc_addr_t ADDR_PB_CTRL_A   = 8'h15;
  localparam csc_addr_t ADDR_PB_CTRL_B   = 8'h16;
  localparam csc_addr_t ADDR_PB_GAIN     = 8'h17;
  localparam csc_addr_t ADDR_REC_CTRL    = 8'h19;
  // ==========================================================
  // field positions
  localparam int BIT_OVERTEMP   = 15;
  localparam int BIT_PIN2       = 13;
  localparam int BIT_PIN1       = 12;
  localparam int BIT_REGLOW     = 0;
  localparam int BIT_PIN_MASK   = 0;
  localparam int BIT_OPEN_DRAIN = 2;
  localparam int BIT_AUTO_INC   = 0;
  localparam int BIT_SIL_MUTE   = 4;
  localparam int BIT_PB_FLIP    = 0;
  localparam int BIT_RAMP       = 4;
  localparam int BIT_FILTER     = 0;
  localparam int BIT_MUTE       = 8;
  localparam int BIT_REC_RFLIP  = 1;
  localparam int BIT_REC_LFLIP  = 0;
  localparam csc_data_t EVENT_BITS = 16'hB001;
  // ==========================================================
  // reset values
  localparam csc_data_t RST_PIN_GATING = 16'h0001;
  localparam csc_data_t RST_SRC_MASKS  = 16'h0000;
  localparam csc_data_t RST_HOST_OPTS  = 16'h0001;
  localparam csc_data_t RST_PB_CTRL_A  = 16'h0010;
  localparam csc_data_t RST_PB_CTRL_B  = 16'h0010;
  localparam csc_data_t RST_PB_GAIN    = 16'h01C0;
  localparam csc_data_t RST_REC_CTRL   = 16'h0100;
  // ==========================================================
  // gain decode and pin function
  localparam logic [7:0]  GAIN_UNITY   = 8'hC0;
  localparam logic [10:0] GAIN_STEP8   = 11'h003;
  localparam logic [3:0]  FN_IRQ_OUT   = 4'h3;
  // ==========================================================
  // timing
  localparam int CLK_MHZ      = 100;
  localparam int RAMP_STEP_NS = 10000;
  localparam int RAMP_CYCLES  = (RAMP_STEP_NS * CLK_MHZ + 999) / 1000;
  localparam int SILENCE_SAMPLES = 1024;
endpackage

// file: verilog/csc_sync.sv
`timescale 1ns/1ns
module csc_sync #(
  parameter int W = 1
) (
  input  wire logic         ref_clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);
  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;
  // only the second stage reads the first
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
    end else begin
      s1_r <= async_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end
  // a bit moves only once stages two and three agree
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sync_out <= '0;
    end else begin
      for (int i = 0; i < W; i++) begin
        if (s2_r[i] == s3_r[i]) begin
          sync_out[i] <= s3_r[i];
        end
      end
    end
  end
endmodule

// file: sim/csc_host_model.sv
`timescale 1ns/1ns
// ==========================================================
// host on the register port: load, then one word
module csc_host_model (
  input  wire logic               ref_clk,
  output logic                    addr_load,
  output csc_pkg::csc_addr_t      addr_in,
  output logic                    word_wr,
  output csc_pkg::csc_data_t      wr_data,
  output logic                    word_rd,
  input  wire csc_pkg::csc_data_t rd_data,
  input  wire logic               rd_valid
);
  import csc_pkg::*;
  initial begin
    addr_load = 1'h0;
    addr_in   = 8'h00;
    word_wr   = 1'h0;
    wr_data   = 16'h0000;
    word_rd   = 1'h0;
  end
  task automatic load(input csc_addr_t a);
    @(posedge ref_clk);
    addr_load <= 1'h1;
    addr_in   <= a;
    @(posedge ref_clk);
    addr_load <= 1'h0;
    // released lines must not keep showing the old value
    addr_in   <= ~a;
  endtask
  task automatic wr(input csc_addr_t a, input csc_data_t d);
    load(a);
    word_wr <= 1'h1;
    wr_data <= d;
    @(posedge ref_clk);
    word_wr <= 1'h0;
    wr_data <= ~d;
  endtask
  task automatic rd(input csc_addr_t a, output csc_data_t d,
                    output logic ok);
    load(a);
    word_rd <= 1'h1;
    @(posedge ref_clk);
    word_rd <= 1'h0;
    @(posedge ref_clk);
    ok = rd_valid;
    d  = rd_data;
  endtask
endmodule

// file: sim/codec_status_irq_path_controls_tb.sv
`timescale 1ns/1ns
module codec_status_irq_path_controls_tb;
  import csc_pkg::*;
  // ==========================================================
  // signals
  logic               ref_clk = 1'h0;
  logic               rst_n = 1'h0;
  logic               i2c_mode, sdo_bit, sdo_active, sdo_o, sdo_oe;
  logic               overtemp_pin, regulator_low_pin, irq_req;
  logic               pin1_event, pin2_event, pb_stb, rec_stb;
  logic [3:0]         pin1_function_select, pin2_function_select;
  logic               pin1_irq_drive, pin2_irq_drive;
  logic               addr_load, word_wr, word_rd, rd_valid;
  csc_addr_t          addr_in, addr_ptr;
  csc_data_t          wr_data, rd_data, v;
  logic signed [15:0] pb_in, pb_out, rec_l_in, rec_r_in;
  logic signed [15:0] rec_l_out, rec_r_out;
  logic signed [10:0] pb_gain_eighth_db;
  logic               pb_gain_mute, playback_filter_select;
  int                 failures = 0;
  int                 compares = 0;
  always #5 ref_clk = ~ref_clk;
  // ==========================================================
  // instances; short counts keep ramp and silence quick
  csc_regbank #(.RAMP_CYC(4), .SIL_LEN(4)) i_csc_regbank (
    .ref_clk(ref_clk), .rst_n(rst_n), .i2c_mode(i2c_mode),
    .addr_load(addr_load), .addr_in(addr_in), .word_wr(word_wr),
    .wr_data(wr_data), .word_rd(word_rd), .rd_data(rd_data),
    .rd_valid(rd_valid), .addr_ptr(addr_ptr), .sdo_bit(sdo_bit),
    .sdo_active(sdo_active), .sdo_o(sdo_o), .sdo_oe(sdo_oe),
    .overtemp_pin(overtemp_pin), .regulator_low_pin(regulator_low_pin),
    .pin1_event(pin1_event), .pin2_event(pin2_event),
    .pin1_function_select(pin1_function_select),
    .pin2_function_select(pin2_function_select),
    .pin1_irq_drive(pin1_irq_drive), .pin2_irq_drive(pin2_irq_drive),
    .irq_req(irq_req), .pb_stb(pb_stb), .pb_in(pb_in), .pb_out(pb_out),
    .pb_gain_eighth_db(pb_gain_eighth_db), .pb_gain_mute(pb_gain_mute),
    .playback_filter_select(playback_filter_select),
    .rec_stb(rec_stb), .rec_l_in(rec_l_in), .rec_r_in(rec_r_in),
    .rec_l_out(rec_l_out), .rec_r_out(rec_r_out));
  csc_host_model i_host (
    .ref_clk(ref_clk), .addr_load(addr_load), .addr_in(addr_in),
    .word_wr(word_wr), .wr_data(wr_data), .word_rd(word_rd),
    .rd_data(rd_data), .rd_valid(rd_valid));
  // ==========================================================
  // helpers
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp,
                     input string m);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected at %0t: %s seen %h wanted %h", $time, m, seen,
               exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  task automatic wr(input csc_addr_t a, input csc_data_t d);
    i_host.wr(a, d);
  endtask
  // a missing rd_valid poisons the word so no compare can pass
  task automatic rdv(input csc_addr_t a, output csc_data_t d);
    logic ok;
    i_host.rd(a, d, ok);
    if (ok !== 1'h1) begin
      d = 'x;
    end
  endtask
  task automatic pbs(input logic [15:0] x);
    pb_in  <= x;
    pb_stb <= 1'h1;
    cyc(1);
    pb_stb <= 1'h0;
    pb_in  <= ~x;
    cyc(1);
  endtask
  task automatic fire(input int b);
    if (b == 15) begin
      overtemp_pin <= 1'h1;
      cyc(8);
      overtemp_pin <= 1'h0;
    end else if (b == 0) begin
      regulator_low_pin <= 1'h1;
      cyc(8);
      regulator_low_pin <= 1'h0;
    end else begin
      pin1_event <= (b == 12);
      pin2_event <= (b == 13);
      cyc(1);
      pin1_event <= 1'h0;
      pin2_event <= 1'h0;
    end
    cyc(6);
  endtask
  // ==========================================================
  // scenarios
  task automatic t_reset();
    csc_addr_t ra [7] = '{8'h12, 8'h13, 8'h14, 8'h15, 8'h16, 8'h17, 8'h19};
    csc_data_t rv [7] = '{16'h0001, 16'h0000, 16'h0001, 16'h0010,
                          16'h0010, 16'h01C0, 16'h0100};
    chk(pb_gain_mute, 1'h1, "mute after reset");
    foreach (ra[i]) begin
      rdv(ra[i], v);
      chk(v, rv[i], "reset value");
    end
    wr(8'h18, 16'h1234);
    rdv(8'h18, v);
    chk(v, 16'h0000, "unmapped read");
  endtask
  task automatic t_live();
    rdv(ADDR_LIVE_FLAGS, v);
    chk(v, 16'h0000, "flags idle");
    overtemp_pin <= 1'h1;
    cyc(6);
    rdv(ADDR_LIVE_FLAGS, v);
    chk(v, 16'h8000, "overtemp flag");
    regulator_low_pin <= 1'h1;
    cyc(6);
    wr(ADDR_LIVE_FLAGS, 16'h0000);
    rdv(ADDR_LIVE_FLAGS, v);
    chk(v, 16'h8001, "flags read only");
    chk(irq_req, 1'h0, "pin mask at reset");
    overtemp_pin <= 1'h0;
    regulator_low_pin <= 1'h0;
    cyc(6);
    rdv(ADDR_LIVE_FLAGS, v);
    chk(v, 16'h0000, "flags clear");
  endtask
  task automatic t_irq();
    int bits [4] = '{15, 13, 12, 0};
    wr(ADDR_SRC_MASKS, 16'hB001);
    wr(ADDR_PIN_GATING, 16'h0000);
    foreach (bits[i]) begin
      wr(ADDR_SRC_MASKS, 16'hB001);
      rdv(ADDR_EVENT_LATCH, v);
      fire(bits[i]);
      chk(irq_req, 1'h0, "masked source");
      wr(ADDR_SRC_MASKS, 16'hB001 & ~(16'h0001 << bits[i]));
      cyc(2);
      chk(irq_req, 1'h1, "open source");
      wr(ADDR_PIN_GATING, 16'h0001);
      cyc(2);
      chk(irq_req, 1'h0, "pin mask set");
      wr(ADDR_PIN_GATING, 16'h0000);
      cyc(2);
      chk(irq_req, 1'h1, "latch held");
      rdv(ADDR_EVENT_LATCH, v);
      chk(v, 16'h0001 << bits[i], "latch word");
      cyc(2);
      chk(irq_req, 1'h0, "latch cleared");
    end
  endtask
  task automatic t_pinfn();
    for (int c = 0; c < 16; c++) begin
      pin1_function_select <= c[3:0];
      pin2_function_select <= ~c[3:0];
      cyc(2);
      chk(pin1_irq_drive, c[3:0] == 4'h3, "pin1 function");
      chk(pin2_irq_drive, c[3:0] == 4'hC, "pin2 function");
    end
  endtask
  task automatic t_autoinc();
    i2c_mode <= 1'h1;
    wr(ADDR_PB_CTRL_B, 16'h0010);
    cyc(1);
    chk(addr_ptr, 8'h17, "pointer steps");
    wr(ADDR_HOST_OPTS, 16'h0000);
    wr(ADDR_PB_CTRL_B, 16'h0010);
    cyc(1);
    chk(addr_ptr, 8'h16, "pointer held");
    wr(ADDR_HOST_OPTS, 16'h0001);
    i2c_mode <= 1'h0;
    wr(ADDR_PB_CTRL_B, 16'h0010);
    cyc(1);
    chk(addr_ptr, 8'h16, "no step in 3-wire");
  endtask
  task automatic t_sdo();
    for (int k = 0; k < 8; k++) begin
      i2c_mode <= k[2];
      wr(ADDR_HOST_OPTS, 16'h0001 | {13'h0000, k[1], 2'h0});
      sdo_bit    <= k[0];
      sdo_active <= 1'h1;
      cyc(2);
      chk({sdo_o, sdo_oe}, (!k[2] && !k[1]) ? {k[0], 1'h1}
                           : {1'h0, !k[0]}, "data line drive");
    end
    // a high bit would hide a stuck enable in open-drain mode
    sdo_bit    <= 1'h0;
    sdo_active <= 1'h0;
    cyc(2);
    chk(sdo_oe, 1'h0, "data line idle");
    i2c_mode <= 1'h0;
  endtask
  task automatic t_play();
    pbs(16'h1234);
    chk(pb_out, 16'h0000, "muted at reset");
    wr(ADDR_PB_CTRL_A, 16'h0000);
    wr(ADDR_PB_GAIN, 16'h00C0);
    repeat (6) pbs(16'h0000);
    pbs(16'h1234);
    chk(pb_out, 16'h1234, "no auto mute");
    wr(ADDR_PB_CTRL_A, 16'h0010);
    repeat (6) pbs(16'h0000);
    pbs(16'h1234);
    chk(pb_out, 16'h0000, "auto mute after silence");
    pbs(16'h1234);
    chk(pb_out, 16'h1234, "auto mute lifts");
    wr(ADDR_PB_CTRL_A, 16'h0001);
    pbs(16'h1234);
    chk(pb_out, 16'hEDCC, "inverted");
    pbs(16'h8000);
    chk(pb_out, 16'h7FFF, "inverted limit");
    wr(ADDR_PB_GAIN, 16'h01C0);
    pbs(16'h1234);
    chk(pb_out, 16'h0000, "muted again");
    wr(ADDR_PB_CTRL_B, 16'h0000);
    wr(ADDR_PB_GAIN, 16'h0001);
    // gain takes one edge to follow, the output register one more
    cyc(3);
    chk(pb_gain_eighth_db, -573, "lowest step");
    chk(playback_filter_select, 1'h0, "normal filter");
    wr(ADDR_PB_GAIN, 16'h00FF);
    cyc(3);
    chk(pb_gain_eighth_db, 189, "top step");
    wr(ADDR_PB_GAIN, 16'h0000);
    cyc(3);
    chk(pb_gain_mute, 1'h1, "code zero mutes");
    wr(ADDR_PB_GAIN, 16'h00C0);
    wr(ADDR_PB_CTRL_B, 16'h0011);
    cyc(2);
    chk(playback_filter_select, 1'h1, "sloping filter");
    wr(ADDR_PB_GAIN, 16'h00C4);
    cyc(3);
    chk(pb_gain_eighth_db < 11'sh00C, 1'h1, "ramp under way");
    for (int i = 0; i < 60 && pb_gain_eighth_db !== 11'sh00C; i++)
      cyc(1);
    chk(pb_gain_eighth_db, 12, "ramp done");
  endtask
  task automatic t_rec();
    csc_data_t c [5] = '{16'h0100, 16'h0000, 16'h0002, 16'h0001, 16'h0103};
    csc_data_t el [5] = '{16'h0000, 16'h0100, 16'h0100, 16'hFF00, 16'h0000};
    csc_data_t er [5] = '{16'h0000, 16'h0200, 16'hFE00, 16'h0200, 16'h0000};
    foreach (c[i]) begin
      wr(ADDR_REC_CTRL, c[i]);
      rec_l_in <= 16'h0100;
      rec_r_in <= 16'h0200;
      rec_stb  <= 1'h1;
      cyc(1);
      rec_stb  <= 1'h0;
      cyc(1);
      chk(rec_l_out, el[i], "record left");
      chk(rec_r_out, er[i], "record right");
    end
  endtask
  task automatic give_verdict();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // ==========================================================
  // main sequence and watchdog
  initial begin
    {i2c_mode, sdo_bit, sdo_active, overtemp_pin} = 4'h0;
    {regulator_low_pin, pin1_event, pin2_event} = 3'h0;
    {pb_stb, rec_stb, pin1_function_select} = 6'h00;
    pin2_function_select = 4'h0;
    {pb_in, rec_l_in, rec_r_in} = 48'h0;
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'h1;
    cyc(1);
    t_reset();
    t_live();
    t_irq();
    t_pinfn();
    t_autoinc();
    t_sdo();
    t_play();
    t_rec();
    give_verdict();
  end
  initial begin
    #200000;
    failures++;
    give_verdict();
  end
endmodule
